/* File: rtl/sjt_edge_if.sv */
// synchronised test pins and clock edge strobes
`timescale 1ns/1ps
interface sjt_edge_if;
   logic rise;
   logic fall;
   logic tms;
   logic tdi;
   modport src (output rise, output fall, output tms, output tdi);
   modport dst (input rise, input fall, input tms, input tdi);
endinterface

/* File: rtl/sjt_pin_sync.sv */
// two-flop synchronisers for test pins and test clock edge detection
`timescale 1ns/1ps
module sjt_pin_sync (
   input wire logic clk, // system clock
   input wire logic reset_n, // async reset, active low
   input wire logic tck, // test clock pin
   input wire logic tms, // mode select pin
   input wire logic tdi, // serial data in pin
   sjt_edge_if.src eo // edges and synced pins
);
   logic [2:0] s1_reg;
   logic [2:0] s2_reg;
   logic tck_d_reg;
   // tms and tdi float high when unconnected, so their idle value is one; tck idles low
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_reg <= 3'h6;
         s2_reg <= 3'h6;
         tck_d_reg <= 1'b0;
      end else begin
         s1_reg <= {tms, tdi, tck};
         s2_reg <= s1_reg;
         tck_d_reg <= s2_reg[0];
      end
   end
   assign eo.rise = s2_reg[0] & ~tck_d_reg;
   assign eo.fall = ~s2_reg[0] & tck_d_reg;
   assign eo.tms = s2_reg[2];
   assign eo.tdi = s2_reg[1];
endmodule

/* File: rtl/sjt_pkg.sv */
// constants and types shared by the test access port design
package sjt_pkg;
   localparam int IR_W = 3;
   localparam int ID_W = 32;
   localparam int BS_W = 109;
   localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
   localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
   localparam logic [IR_W-1:0] INS_SAMPLEZ = 3'h2;
   localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
   localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;
   // capture pattern of the instruction register, low bits 01
   localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;
   // identification value, arbitrary
   localparam logic [ID_W-1:0] ID_VALUE = 32'h00a5a5a5;
   localparam int RESET_TMS_EDGES = 5;
   typedef enum logic [3:0] {
      SJT_RESET = 4'h0, SJT_IDLE = 4'h1, SJT_SEL_DR = 4'h2, SJT_CAP_DR = 4'h3,
      SJT_SH_DR = 4'h4, SJT_EX1_DR = 4'h5, SJT_PA_DR = 4'h6, SJT_EX2_DR = 4'h7,
      SJT_UP_DR = 4'h8, SJT_SEL_IR = 4'h9, SJT_CAP_IR = 4'ha, SJT_SH_IR = 4'hb,
      SJT_EX1_IR = 4'hc, SJT_PA_IR = 4'hd, SJT_EX2_IR = 4'he, SJT_UP_IR = 4'hf
   } sjt_state_t;
endpackage

/* File: rtl/sjt_tap.sv */
// test access port controller with instruction, id, bypass and boundary registers
`timescale 1ns/1ps
module sjt_tap
   import sjt_pkg::*;
#(
   parameter int BSW = BS_W // boundary register length
) (
   input wire logic clk, // system clock, 10 MHz
   input wire logic reset_n, // power-up reset, active low
   input wire logic tck, // test clock pin
   input wire logic tms, // mode select pin
   input wire logic tdi, // serial data in pin
   input wire logic [BSW-1:0] pad_in, // memory pad levels to capture
   output logic tdo, // serial data out
   output logic tdo_oe, // serial out driven
   output logic mem_out_hiz, // force memory outputs high-z
   output logic extest_drive, // boundary cells drive output pads
   output logic [BSW-1:0] bs_out // boundary update latch
);
   import sjt_pkg::*;
   sjt_edge_if eg ();
   sjt_pin_sync u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .tck(tck),
      .tms(tms),
      .tdi(tdi),
      .eo(eg)
   );
   sjt_state_t st_reg, st_next;
   logic [IR_W-1:0] ir_sh_reg, ir_reg;
   logic [ID_W-1:0] id_sh_reg;
   logic [BSW-1:0] bs_sh_reg, bs_up_reg;
   logic bp_reg;
   logic tdo_reg, oe_reg, hiz_reg, ext_reg;
   logic [2:0] hi_cnt_reg;
   logic [BSW-1:0] pad_s1_reg, pad_s2_reg;
   wire sel_id = (ir_reg == INS_IDCODE);
   wire sel_bs = (ir_reg == INS_EXTEST) | (ir_reg == INS_SAMPLEZ)
      | (ir_reg == INS_SAMPLE);
   wire in_ir = (st_reg == SJT_SH_IR);
   wire in_dr = (st_reg == SJT_SH_DR);
   wire sel_bit = in_ir ? ir_sh_reg[0] : sel_id ? id_sh_reg[0] : sel_bs ? bs_sh_reg[0] : bp_reg;
   wire t = eg.tms;
   always_comb begin
      case (st_reg)
         SJT_RESET: st_next = t ? SJT_RESET : SJT_IDLE;
         SJT_IDLE: st_next = t ? SJT_SEL_DR : SJT_IDLE;
         SJT_SEL_DR: st_next = t ? SJT_SEL_IR : SJT_CAP_DR;
         SJT_CAP_DR: st_next = t ? SJT_EX1_DR : SJT_SH_DR;
         SJT_SH_DR: st_next = t ? SJT_EX1_DR : SJT_SH_DR;
         SJT_EX1_DR: st_next = t ? SJT_UP_DR : SJT_PA_DR;
         SJT_PA_DR: st_next = t ? SJT_EX2_DR : SJT_PA_DR;
         SJT_EX2_DR: st_next = t ? SJT_UP_DR : SJT_SH_DR;
         SJT_UP_DR: st_next = t ? SJT_SEL_DR : SJT_IDLE;
         SJT_SEL_IR: st_next = t ? SJT_RESET : SJT_CAP_IR;
         SJT_CAP_IR: st_next = t ? SJT_EX1_IR : SJT_SH_IR;
         SJT_SH_IR: st_next = t ? SJT_EX1_IR : SJT_SH_IR;
         SJT_EX1_IR: st_next = t ? SJT_UP_IR : SJT_PA_IR;
         SJT_PA_IR: st_next = t ? SJT_EX2_IR : SJT_PA_IR;
         SJT_EX2_IR: st_next = t ? SJT_UP_IR : SJT_SH_IR;
         SJT_UP_IR: st_next = t ? SJT_SEL_DR : SJT_IDLE;
         default: st_next = SJT_RESET;
      endcase
   end
   // state and instruction; reset forces idcode
   // update taken on the rise leaving update-ir, outputs follow at the next fall
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg <= SJT_RESET;
         ir_reg <= INS_IDCODE;
      end else if (eg.rise) begin
         st_reg <= st_next;
         if (st_reg == SJT_RESET)
            ir_reg <= INS_IDCODE;
         else if (st_reg == SJT_UP_IR)
            ir_reg <= ir_sh_reg;
      end
   end
   // shift paths, shifting toward bit 0 with serial in at the top
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ir_sh_reg <= IR_CAPTURE;
         id_sh_reg <= ID_VALUE;
         bp_reg <= 1'b0;
      end else if (eg.rise) begin
         if (st_reg == SJT_CAP_IR)
            ir_sh_reg <= IR_CAPTURE;
         else if (in_ir)
            ir_sh_reg <= {eg.tdi, ir_sh_reg[IR_W-1:1]};
         if (st_reg == SJT_CAP_DR)
            id_sh_reg <= ID_VALUE;
         else if (in_dr && sel_id)
            id_sh_reg <= {eg.tdi, id_sh_reg[ID_W-1:1]};
         if (st_reg == SJT_CAP_DR)
            bp_reg <= 1'b0;
         else if (in_dr)
            bp_reg <= eg.tdi;
      end
   end
   // pads move on the memory clocks, so two stages before capture;
   // the tester keeps them still across the capture window, hiding the latency
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pad_s1_reg <= '0;
         pad_s2_reg <= '0;
      end else begin
         pad_s1_reg <= pad_in;
         pad_s2_reg <= pad_s1_reg;
      end
   end
   // boundary capture of pad levels, update latch only in update-dr
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bs_sh_reg <= '0;
         bs_up_reg <= '0;
      end else if (eg.rise) begin
         if (st_reg == SJT_CAP_DR && sel_bs)
            bs_sh_reg <= pad_s2_reg;
         else if (in_dr && sel_bs)
            bs_sh_reg <= {eg.tdi, bs_sh_reg[BSW-1:1]};
         if (st_reg == SJT_UP_DR && sel_bs)
            bs_up_reg <= bs_sh_reg;
      end
   end
   // outputs launched on the falling edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tdo_reg <= 1'b0;
         oe_reg <= 1'b0;
         hiz_reg <= 1'b0;
         ext_reg <= 1'b0;
      end else if (eg.fall) begin
         tdo_reg <= sel_bit;
         oe_reg <= in_ir | in_dr;
         hiz_reg <= (ir_reg == INS_SAMPLEZ);
         ext_reg <= (ir_reg == INS_EXTEST);
      end
   end
   assign tdo = tdo_reg;
   assign tdo_oe = oe_reg;
   assign mem_out_hiz = hiz_reg;
   assign extest_drive = ext_reg;
   assign bs_out = bs_up_reg;
   // helper: rising edges seen with mode select high in a row
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         hi_cnt_reg <= 3'h0;
      else if (eg.rise)
         hi_cnt_reg <= !t ? 3'h0 : (hi_cnt_reg == 3'h7) ? 3'h7 : hi_cnt_reg + 3'h1;
   end
   sequence tms_high_run;
      hi_cnt_reg >= 3'(RESET_TMS_EDGES);
   endsequence
   five_high_reset_a: assert property (@(posedge clk) disable iff (!reset_n)
      tms_high_run |-> st_reg == SJT_RESET) else $error("five high edges did not reset");
   reset_loads_id_a: assert property (@(posedge clk) disable iff (!reset_n)
      eg.rise && st_reg == SJT_RESET |=> ir_reg == INS_IDCODE) else $error("idcode not loaded");
   tdo_on_fall_a: assert property (@(posedge clk) disable iff (!reset_n)
      !eg.fall |=> $stable(tdo)) else $error("tdo moved off falling edge");
   state_on_rise_a: assert property (@(posedge clk) disable iff (!reset_n)
      !eg.rise |=> $stable(st_reg)) else $error("state moved off rising edge");
   ir_update_only_a: assert property (@(posedge clk) disable iff (!reset_n)
      $changed(ir_reg) |-> $past(st_reg) inside {SJT_UP_IR, SJT_RESET})
      else $error("instruction changed outside update");
   bypass_path_a: assert property (@(posedge clk) disable iff (!reset_n)
      eg.rise && in_dr && ir_reg == INS_BYPASS |=> bp_reg == $past(eg.tdi))
      else $error("bypass bit not shifted");
   samplez_hiz_a: assert property (@(posedge clk) disable iff (!reset_n)
      eg.fall |=> mem_out_hiz == ($past(ir_reg) == INS_SAMPLEZ)) else $error("hi-z wrong");
   tdo_select_a: assert property (@(posedge clk) disable iff (!reset_n)
      eg.fall |=> tdo == $past(sel_bit)) else $error("wrong register on tdo");
   ir_capture_a: assert property (@(posedge clk) disable iff (!reset_n)
      eg.rise && st_reg == SJT_CAP_IR |=> ir_sh_reg == IR_CAPTURE) else $error("ir capture");
   sequence dr_capture_step;
      eg.rise && st_reg == SJT_CAP_DR;
   endsequence
   sequence ir_update_step;
      eg.rise && st_reg == SJT_UP_IR;
   endsequence
   sequence dr_update_step;
      eg.rise && st_reg == SJT_UP_DR;
   endsequence
   id_capture_a: assert property (@(posedge clk) disable iff (!reset_n)
      dr_capture_step |=> id_sh_reg == ID_VALUE)
      else $error("id value not captured");
   pad_capture_a: assert property (@(posedge clk) disable iff (!reset_n)
      dr_capture_step ##0 sel_bs |=> bs_sh_reg == $past(pad_s2_reg))
      else $error("pads not captured");
   ir_takes_shift_a: assert property (@(posedge clk) disable iff (!reset_n)
      ir_update_step |=> ir_reg == $past(ir_sh_reg))
      else $error("instruction not updated");
   bs_update_a: assert property (@(posedge clk) disable iff (!reset_n)
      dr_update_step ##0 sel_bs |=> bs_out == $past(bs_sh_reg))
      else $error("boundary not updated");
   bs_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      $changed(bs_out) |-> $past(st_reg) == SJT_UP_DR)
      else $error("boundary changed outside update");
   extest_drive_a: assert property (@(posedge clk) disable iff (!reset_n)
      eg.fall |=> extest_drive == ($past(ir_reg) == INS_EXTEST))
      else $error("extest drive wrong");
   oe_shift_a: assert property (@(posedge clk) disable iff (!reset_n)
      eg.fall |=> tdo_oe == $past(in_ir | in_dr))
      else $error("serial out enable wrong");
   reserved_bypass_a: assert property (@(posedge clk) disable iff (!reset_n)
      eg.fall && in_dr && !sel_id && !sel_bs |=> tdo == $past(bp_reg))
      else $error("reserved code not bypassed");
   id_shift_a: assert property (@(posedge clk) disable iff (!reset_n)
      eg.rise && in_dr && sel_id |=> id_sh_reg[ID_W-1] == $past(eg.tdi))
      else $error("id register not shifted");
   ir_shift_a: assert property (@(posedge clk) disable iff (!reset_n)
      eg.rise && in_ir |=> ir_sh_reg[IR_W-1] == $past(eg.tdi))
      else $error("instruction register not shifted");
endmodule

/* File: tb/sjt_tap_test.sv */
// self-checking bench for the test access port
`timescale 1ns/1ps
module sjt_tap_test;
   import sjt_pkg::*;
   localparam int BSW = 8;
   logic clk, reset_n, tck, tms, tdi, tdo, tdo_oe, mem_out_hiz, extest_drive, oe;
   logic [BSW-1:0] pad_in, bs_out;
   logic [31:0] sh;
   int failures = 0;
   int cmp_count = 0;
   sjt_tap #(.BSW(BSW)) i_dut (.clk(clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
      .pad_in(pad_in), .tdo(tdo), .tdo_oe(tdo_oe), .mem_out_hiz(mem_out_hiz),
      .extest_drive(extest_drive), .bs_out(bs_out));
   sjt_tester i_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // tms values lsb first, tdi left high
   task automatic walk(input logic [7:0] m, input int n);
      logic q;
      for (int i = 0; i < n; i++) i_tester.step(m[i], 1'b1, q);
   endtask
   // idle to shift, n bits lsb first, then update and back to idle
   task automatic scan(input bit ir, input logic [31:0] din, input int n, output logic [31:0] dout);
      logic q;
      dout = '0;
      walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
      #400;
      oe = tdo_oe;
      for (int i = 0; i < n; i++) begin
         i_tester.step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      walk(8'h01, 2);
      // outputs follow the last fall only a few clocks later
      #400;
   endtask
   task automatic t_id();
      walk(8'h00, 1);
      scan(0, '0, 32, sh);
      chk("idcode", sh, ID_VALUE);
      chk("oe in shift", oe, 1'b1);
      chk("oe idle", tdo_oe, 1'b0);
   endtask
   task automatic t_bypass();
      logic [2:0] ins[4] = '{INS_BYPASS, 3'h3, 3'h5, 3'h6};
      foreach (ins[k]) begin
         scan(1, 32'(ins[k]), 3, sh);
         chk("ir capture", sh, 32'(IR_CAPTURE));
         scan(0, 32'h2d, 8, sh);
         chk("bypass", sh, 32'h5a);
      end
      walk(8'h01, 3);
      walk(8'h1f, 5);
      walk(8'h00, 1);
      scan(0, '0, 32, sh);
      chk("idcode after reset", sh, ID_VALUE);
   endtask
   task automatic t_bound();
      scan(1, 32'(INS_SAMPLEZ), 3, sh);
      chk("hiz", mem_out_hiz, 1'b1);
      scan(0, 32'h96, 8, sh);
      chk("samplez capture", sh, 32'hc3);
      chk("samplez update", bs_out, 8'h96);
      scan(1, 32'(INS_SAMPLE), 3, sh);
      chk("sample hiz", {mem_out_hiz, extest_drive}, 2'b00);
      scan(1, 32'(INS_EXTEST), 3, sh);
      chk("extest drive", {mem_out_hiz, extest_drive}, 2'b01);
      chk("no update in ir", bs_out, 8'h96);
      scan(0, 32'h5a, 8, sh);
      chk("extest capture", sh, 32'hc3);
      chk("extest update", bs_out, 8'h5a);
   endtask
   initial begin
      reset_n = 1'b0;
      pad_in = 8'hc3;
      repeat (6) @(posedge clk);
      #1 reset_n = 1'b1;
      #400;
      t_id();
      t_bypass();
      t_bound();
      test_done();
   end
   initial begin
      #1_000_000;
      failures++;
      test_done();
   end
endmodule

/* File: tb/sjt_tester.sv */
// boundary-scan tester model: makes the test clock, drives pins, samples serial out
`timescale 1ns/1ps
module sjt_tester (
   output logic tck, // test clock
   output logic tms, // mode select
   output logic tdi, // serial data in
   input wire logic tdo // serial out of the device
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end
   // one 800 ns test clock period; pins held through the high phase
   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #500;
      q = tdo;
      tck = 1'b1;
      #300;
      tck = 1'b0;
      tms = 1'b1; // released pins float high
      tdi = 1'b1;
   endtask
endmodule
